/* logic/codec_pkg.sv */
package codec_pkg;

  // Frame sync modes, two-bit field
  typedef enum logic [1:0] {
    FS_MULTI = 2'b00,
    FS_I2S = 2'b01,
    FS_AC16 = 2'b10,
    FS_AC20 = 2'b11
  } fs_mode_t;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // interface_control_reg_a fields
  localparam int EN_BIT = 0;
  localparam int DIR_BIT = 1;
  localparam int MODE_LSB = 2;
  localparam int GEN_BIT = 4;
  localparam logic [7:0] CTRL_A_RST = 8'h00;

  // interface_control_reg_b fields
  localparam int WS_LSB = 0;
  localparam int FL_LSB = 4;
  localparam logic [7:0] CTRL_B_RST = 8'h00;

  // Status register fields
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_FS_BIT = 1;
  localparam int ST_CNT_LSB = 16;

  // Fixed AC-Link framing
  localparam logic [3:0] AC_COUNT_MAX = 4'hF;
  localparam logic [7:0] AC_SYNC_HIGH = 8'h10;
  localparam int AC_FRAME_BITS = 256;

  // Counter start values
  localparam logic [3:0] CNT4_ZERO = 4'h0;
  localparam logic [7:0] POS_ZERO = 8'h00;

  // Bit clock generator timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int BCLK_PERIOD_NS = 160;
  localparam int BCLK_HALF_CYC = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Pin index within the four-pin group
  localparam int PIN_BCLK = 0;
  localparam int PIN_FS = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_SDO = 3;

endpackage

/* logic/codec_serial_frame_sync.sv */
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - Clearing enable resets all counters but the bit clock divider
// - Internal bit clock follows the generator bit, even while enable is clear
// - Enabled interface owns its four pins
// - Bit clock generator may run alone
// - Word counter period is field plus one
// - AC-Link modes ignore word length field
// - Frame counter steps on word wrap
// - Frame length is word times field plus one
// - AC-Link frames last 256 bit clocks
// - Two-bit field selects four sync modes
// - Direction bit picks master or slave
// - Master starts sync at frame counter zero in pulse modes, I2S at half frame
// - Multi-channel sync high one bit clock
// - AC-Link sync high 16, low 240
// - I2S sync has half-frame duty
// - Either I2S edge marks a boundary
module codec_serial_frame_sync #(
  parameter int BCLK_HALF = codec_pkg::BCLK_HALF_CYC
) (
  input wire logic clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic bit_clock_pin_i, // Bit clock pin level, link clock
  output logic bit_clock_pin_o, // Bit clock pin drive
  output logic bit_clock_pin_oe_o, // Bit clock pin enable
  input wire logic frame_sync_pin_i, // Frame sync pin level
  output logic frame_sync_pin_o, // Frame sync pin drive
  output logic frame_sync_pin_oe_o, // Frame sync pin enable
  output logic serial_data_in_pin_o, // Data in pin drive
  output logic serial_data_in_pin_oe_o, // Data in pin enable
  output logic serial_data_out_pin_o, // Data out pin drive
  output logic serial_data_out_pin_oe_o, // Data out pin enable
  input wire logic [3:0] output_latch_reg_i, // Port latch values
  input wire logic [3:0] pin_direction_reg_i // Port direction, 1 = input
);

  // Parameter range check
  if (BCLK_HALF < 1 || BCLK_HALF > 255) begin : g_bad_half
    $error("BCLK_HALF must lie in 1..255");
  end

  // System clock domain state
  typedef struct packed {
    logic en;
    logic dir;
    codec_pkg::fs_mode_t mode;
    logic gen;
    logic [3:0] ws;
    logic [3:0] fl;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] div;
    logic bclk;
    logic act_meta;
    logic act_sync;
    logic fs_meta;
    logic fs_sync;
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_prev;
    logic [15:0] frames;
  } sys_t;

  // Link clock domain state
  typedef struct packed {
    logic en_meta;
    logic en_sync;
    logic run;
    logic dir;
    codec_pkg::fs_mode_t mode;
    logic [3:0] ws;
    logic [3:0] fl;
    logic [3:0] word;
    logic [3:0] frame;
    logic [7:0] pos;
    logic fs;
    logic fsi_meta;
    logic fsi_sync;
    logic fsi_prev;
    logic tgl;
  } link_t;

  sys_t s_ff;
  sys_t nxt_s;
  link_t l_ff;
  link_t nxt_l;

  // AC-Link mode test
  function automatic logic is_ac(input codec_pkg::fs_mode_t m);
    return (m == codec_pkg::FS_AC16) || (m == codec_pkg::FS_AC20);
  endfunction

  // Effective counter limit, fixed in AC-Link
  function automatic logic [3:0] eff_max(input codec_pkg::fs_mode_t m, input logic [3:0] v);
    return is_ac(m) ? codec_pkg::AC_COUNT_MAX : v;
  endfunction

  // Frame length in bit clocks
  function automatic logic [8:0] frame_len(input logic [3:0] w, input logic [3:0] f);
    logic [17:0] prod;
    prod = 18'((9'(w) + 9'h001) * (9'(f) + 9'h001));
    return prod[8:0];
  endfunction

  // Master sync level at a counter position
  function automatic logic fs_shape(input codec_pkg::fs_mode_t m, input logic [3:0] w,
                                    input logic [3:0] f, input logic [7:0] p,
                                    input logic [8:0] len);
    logic r;
    r = 1'b0;
    case (m)
      codec_pkg::FS_MULTI: r = (w == codec_pkg::CNT4_ZERO) && (f == codec_pkg::CNT4_ZERO);
      codec_pkg::FS_I2S: r = {1'b0, p} >= (len >> 1);
      codec_pkg::FS_AC16, codec_pkg::FS_AC20: r = (f == codec_pkg::CNT4_ZERO);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic wb_req;
  logic [8:0] len_cur;
  logic wrap_w;
  logic wrap_f;
  logic fsi_rise;
  logic fsi_fall;
  logic slave_start;

  assign wb_req = wb_cyc_i && wb_stb_i;
  assign len_cur = frame_len(eff_max(l_ff.mode, l_ff.ws), eff_max(l_ff.mode, l_ff.fl));
  assign wrap_w = l_ff.word == eff_max(l_ff.mode, l_ff.ws);
  assign wrap_f = wrap_w && (l_ff.frame == eff_max(l_ff.mode, l_ff.fl));
  assign fsi_rise = l_ff.fsi_sync && !l_ff.fsi_prev;
  assign fsi_fall = !l_ff.fsi_sync && l_ff.fsi_prev;
  // I2S frame opens on the falling edge, other modes on the rising edge
  assign slave_start = (l_ff.mode == codec_pkg::FS_I2S) ? fsi_fall : fsi_rise;

  // System domain next state: bus slave, generator, status
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = wb_req && !s_ff.ack;
    if (wb_req && !s_ff.ack) begin
      nxt_s.rdata = 32'h0000_0000;
      case (wb_adr_i)
        codec_pkg::OFS_CTRL_A: begin
          nxt_s.rdata[codec_pkg::EN_BIT] = s_ff.en;
          nxt_s.rdata[codec_pkg::DIR_BIT] = s_ff.dir;
          nxt_s.rdata[codec_pkg::MODE_LSB +: 2] = s_ff.mode;
          nxt_s.rdata[codec_pkg::GEN_BIT] = s_ff.gen;
        end
        codec_pkg::OFS_CTRL_B: begin
          nxt_s.rdata[codec_pkg::WS_LSB +: 4] = s_ff.ws;
          nxt_s.rdata[codec_pkg::FL_LSB +: 4] = s_ff.fl;
        end
        codec_pkg::OFS_STATUS: begin
          nxt_s.rdata[codec_pkg::ST_ACTIVE_BIT] = s_ff.act_sync;
          nxt_s.rdata[codec_pkg::ST_FS_BIT] = s_ff.fs_sync;
          nxt_s.rdata[codec_pkg::ST_CNT_LSB +: 16] = s_ff.frames;
        end
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
    // Writes land on the acknowledged edge; setup fields lock while enabled
    if (wb_req && s_ff.ack && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == codec_pkg::OFS_CTRL_A) begin
        nxt_s.en = wb_dat_i[codec_pkg::EN_BIT];
        nxt_s.gen = wb_dat_i[codec_pkg::GEN_BIT];
        if (!s_ff.en) begin
          nxt_s.dir = wb_dat_i[codec_pkg::DIR_BIT];
          nxt_s.mode = codec_pkg::fs_mode_t'(wb_dat_i[codec_pkg::MODE_LSB +: 2]);
        end
      end
      if (wb_adr_i == codec_pkg::OFS_CTRL_B && !s_ff.en) begin
        nxt_s.ws = wb_dat_i[codec_pkg::WS_LSB +: 4];
        nxt_s.fl = wb_dat_i[codec_pkg::FL_LSB +: 4];
      end
    end
    // Bit clock divider, held at rest while the generator is off
    if (!s_ff.gen) begin
      nxt_s.div = 8'h00;
      nxt_s.bclk = 1'b0;
    end else if (s_ff.div == 8'(BCLK_HALF - 1)) begin
      nxt_s.div = 8'h00;
      nxt_s.bclk = !s_ff.bclk;
    end else begin
      nxt_s.div = s_ff.div + 8'h01;
    end
    // Status levels and frame events from the link
    nxt_s.act_meta = l_ff.en_sync;
    nxt_s.act_sync = s_ff.act_meta;
    nxt_s.fs_meta = frame_sync_pin_i;
    nxt_s.fs_sync = s_ff.fs_meta;
    nxt_s.tgl_meta = l_ff.tgl;
    nxt_s.tgl_sync = s_ff.tgl_meta;
    nxt_s.tgl_prev = s_ff.tgl_sync;
    if (!s_ff.en) begin
      nxt_s.frames = 16'h0000;
    end else if (s_ff.tgl_sync != s_ff.tgl_prev) begin
      nxt_s.frames = s_ff.frames + 16'h0001;
    end
  end

  // System domain registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Link domain next state: counters and frame sync
  always_comb begin
    nxt_l = l_ff;
    nxt_l.en_meta = s_ff.en;
    nxt_l.en_sync = l_ff.en_meta;
    nxt_l.fsi_meta = frame_sync_pin_i;
    nxt_l.fsi_sync = l_ff.fsi_meta;
    nxt_l.fsi_prev = l_ff.fsi_sync;
    if (!l_ff.en_sync) begin
      // Setup is stable here, bus locks it while enabled
      nxt_l.dir = s_ff.dir;
      nxt_l.mode = s_ff.mode;
      nxt_l.ws = s_ff.ws;
      nxt_l.fl = s_ff.fl;
      nxt_l.run = 1'b0;
      nxt_l.word = codec_pkg::CNT4_ZERO;
      nxt_l.frame = codec_pkg::CNT4_ZERO;
      nxt_l.pos = codec_pkg::POS_ZERO;
      nxt_l.fs = 1'b0;
    end else if (!l_ff.run) begin
      // First enabled edge opens frame zero
      nxt_l.run = 1'b1;
      nxt_l.tgl = !l_ff.tgl;
      nxt_l.fs = !l_ff.dir && fs_shape(l_ff.mode, codec_pkg::CNT4_ZERO,
                                       codec_pkg::CNT4_ZERO, codec_pkg::POS_ZERO,
                                       len_cur);
    end else begin
      nxt_l.word = wrap_w ? codec_pkg::CNT4_ZERO : l_ff.word + 4'h1;
      if (wrap_f) begin
        nxt_l.frame = codec_pkg::CNT4_ZERO;
        nxt_l.pos = codec_pkg::POS_ZERO;
      end else begin
        nxt_l.frame = wrap_w ? l_ff.frame + 4'h1 : l_ff.frame;
        nxt_l.pos = l_ff.pos + 8'h01;
      end
      if (l_ff.dir) begin
        if (slave_start) begin
          nxt_l.word = codec_pkg::CNT4_ZERO;
          nxt_l.frame = codec_pkg::CNT4_ZERO;
          nxt_l.pos = codec_pkg::POS_ZERO;
        end else if (l_ff.mode == codec_pkg::FS_I2S && fsi_rise) begin
          nxt_l.word = codec_pkg::CNT4_ZERO;
        end
        nxt_l.fs = 1'b0;
        if (slave_start) begin
          nxt_l.tgl = !l_ff.tgl;
        end
      end else begin
        nxt_l.fs = fs_shape(l_ff.mode, nxt_l.word, nxt_l.frame, nxt_l.pos,
                            len_cur);
        if (wrap_f) begin
          nxt_l.tgl = !l_ff.tgl;
        end
      end
    end
  end

  // Link domain registers, clocked by the bit clock pin
  always_ff @(posedge bit_clock_pin_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end

  // Bus outputs
  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.rdata;

  // Pin ownership: interface overrides port latch and direction
  always_comb begin
    bit_clock_pin_o = output_latch_reg_i[codec_pkg::PIN_BCLK];
    bit_clock_pin_oe_o = !pin_direction_reg_i[codec_pkg::PIN_BCLK];
    if (s_ff.gen) begin
      bit_clock_pin_o = s_ff.bclk;
      bit_clock_pin_oe_o = 1'b1;
    end else if (s_ff.en) begin
      bit_clock_pin_oe_o = 1'b0;
    end
    frame_sync_pin_o = output_latch_reg_i[codec_pkg::PIN_FS];
    frame_sync_pin_oe_o = !pin_direction_reg_i[codec_pkg::PIN_FS];
    serial_data_in_pin_o = output_latch_reg_i[codec_pkg::PIN_SDI];
    serial_data_in_pin_oe_o = !pin_direction_reg_i[codec_pkg::PIN_SDI];
    serial_data_out_pin_o = output_latch_reg_i[codec_pkg::PIN_SDO];
    serial_data_out_pin_oe_o = !pin_direction_reg_i[codec_pkg::PIN_SDO];
    if (s_ff.en) begin
      frame_sync_pin_o = l_ff.fs;
      frame_sync_pin_oe_o = !s_ff.dir;
      serial_data_in_pin_o = 1'b0;
      serial_data_in_pin_oe_o = 1'b0;
      serial_data_out_pin_o = 1'b0;
      serial_data_out_pin_oe_o = 1'b1;
    end
  end

  // Disabled link holds every counter at zero
  chk_disable_clears: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    !l_ff.en_sync |=> (l_ff.word == 4'h0) && (l_ff.frame == 4'h0) && (l_ff.pos == 8'h00))
    else $error("counters not cleared while disabled");

  // Generator off keeps bit clock low
  chk_gen_stopped: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !s_ff.gen |=> !s_ff.bclk && (s_ff.div == 8'h00))
    else $error("bit clock runs while generator off");

  // Enabled interface drives data out pin
  chk_pins_owned: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_ff.en |-> serial_data_out_pin_oe_o && !serial_data_in_pin_oe_o
                && (frame_sync_pin_oe_o == !s_ff.dir))
    else $error("pin direction not owned while enabled");

  // Generator alone drives the bit clock pin
  chk_gen_alone: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_ff.gen |-> bit_clock_pin_oe_o && (bit_clock_pin_o == s_ff.bclk))
    else $error("bit clock pin not taken by generator");

  // Word counter wraps at field value
  chk_word_wrap: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    l_ff.run && l_ff.en_sync && !l_ff.dir && !is_ac(l_ff.mode) && l_ff.word == l_ff.ws
    |=> l_ff.word == 4'h0)
    else $error("word counter missed its wrap");

  // AC-Link word period fixed at 16
  chk_ac_word: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    l_ff.run && l_ff.en_sync && !l_ff.dir && is_ac(l_ff.mode) && l_ff.word == 4'hE
    |=> l_ff.word == 4'hF)
    else $error("AC-Link word period not fixed");

  // Frame counter steps once per word wrap
  chk_frame_step: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    l_ff.run && l_ff.en_sync && !l_ff.dir && wrap_w && !wrap_f
    |=> l_ff.frame == $past(l_ff.frame) + 4'h1)
    else $error("frame counter did not step");

  // Frame wrap coincides with position at length minus one
  chk_frame_len: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    l_ff.run && l_ff.en_sync && !l_ff.dir |-> wrap_f == ({1'b0, l_ff.pos} == len_cur - 9'h001))
    else $error("frame length mismatch");

  // AC-Link master sync repeats every 256 bit clocks
  chk_ac_period: assert property (@(posedge bit_clock_pin_i)
    disable iff (!arst_n_i || !l_ff.en_sync)
    $rose(l_ff.fs) && !l_ff.dir && is_ac(l_ff.mode)
    |-> ##256 $rose(l_ff.fs))
    else $error("AC-Link frame not 256 bit clocks");

  // AC-Link sync falls after exactly 16 high bit clocks
  chk_ac_high: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    $fell(l_ff.fs) && l_ff.en_sync && is_ac(l_ff.mode) |-> l_ff.pos == codec_pkg::AC_SYNC_HIGH)
    else $error("AC-Link sync high time wrong");

  // Master sync high at frame zero in pulse modes
  chk_master_start: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    l_ff.run && l_ff.en_sync && !l_ff.dir && l_ff.mode != codec_pkg::FS_I2S
    && l_ff.word == 4'h0 && l_ff.frame == 4'h0 |-> l_ff.fs)
    else $error("master sync missing at frame start");

  // Multi-channel pulse lasts one bit clock
  chk_mc_pulse: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    l_ff.fs && l_ff.mode == codec_pkg::FS_MULTI && l_ff.en_sync && !wrap_f |=> !l_ff.fs)
    else $error("multi-channel pulse too long");

  // I2S level follows the half-frame split
  chk_i2s_half: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    l_ff.run && l_ff.en_sync && !l_ff.dir && l_ff.mode == codec_pkg::FS_I2S
    |-> l_ff.fs == ({1'b0, l_ff.pos} >= (len_cur >> 1)))
    else $error("I2S duty wrong");

  // Slave realigns on the codec's frame edge
  chk_slave_align: assert property (@(posedge bit_clock_pin_i) disable iff (!arst_n_i)
    l_ff.run && l_ff.en_sync && l_ff.dir && slave_start
    |=> l_ff.word == 4'h0 && l_ff.frame == 4'h0 && !l_ff.fs)
    else $error("slave counters not aligned");

endmodule

/* tb/codec_partner.sv */
`timescale 1ns/1ns
// External codec: bit clock source and frame sync master when asked
module codec_partner (
  input wire logic run_i, // Bit clock runs while high
  input wire logic slave_i, // Codec owns frame sync
  input wire logic [8:0] len_i, // Frame length in bit clocks
  output logic bclk_o, // Codec bit clock
  output logic fs_o // Codec frame sync drive
);
  int pos;

  // Free phase offset against the system clock; clock stands while stopped
  initial begin
    bclk_o = 1'b0;
    fs_o = 1'b0;
    pos = 0;
    #37;
    forever begin
      #80;
      if (run_i) begin
        bclk_o = ~bclk_o;
      end
    end
  end

  // Sync launched on the falling edge, one bit clock high per frame
  always @(negedge bclk_o) begin
    if (slave_i) begin
      fs_o <= (pos == 0);
      pos <= (pos + 1 >= int'(len_i)) ? 0 : pos + 1;
    end else begin
      fs_o <= ~fs_o; // Released line keeps changing
      pos <= 0;
    end
  end
endmodule

/* tb/test_codec_serial_frame_sync.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module test_codec_serial_frame_sync;
  localparam int HALF = 20;
  localparam int CEIL = 80000;
  typedef struct {
    logic [1:0] mode;
    logic [3:0] ws;
    logic [3:0] fl;
    int hi;
    int per;
  } row_t;
  logic clk_i, arst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, latch, dir;
  logic [31:0] wb_dat_i, wb_dat_o, rd, s1;
  logic bclk_o, bclk_oe, fs_o, fs_oe, sdi_o, sdi_oe, sdo_o, sdo_oe;
  logic run, slave, c_bclk, c_fs;
  logic [8:0] len;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int hi, per, tg;
  wire bclk_w = bclk_oe ? bclk_o : c_bclk;
  wire fs_w = fs_oe ? fs_o : c_fs;
  wire [7:0] pins = {bclk_oe, bclk_o, fs_oe, fs_o, sdi_oe, sdi_o, sdo_oe, sdo_o};
  // Mode, word length-1, frame words-1, sync high and frame length
  row_t rows [6] = '{
    '{2'h0, 4'h1, 4'h1, 1, 4},
    '{2'h0, 4'hF, 4'h0, 1, 16},
    '{2'h1, 4'h3, 4'h1, 4, 8},
    '{2'h1, 4'h2, 4'h0, 2, 3},
    '{2'h2, 4'h1, 4'h1, 16, 256},
    '{2'h3, 4'h0, 4'h0, 16, 256}
  };

  codec_partner codec_partner_inst (.run_i(run), .slave_i(slave), .len_i(len),
    .bclk_o(c_bclk), .fs_o(c_fs));

  codec_serial_frame_sync #(.BCLK_HALF(HALF)) codec_serial_frame_sync_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bit_clock_pin_i(bclk_w),
    .bit_clock_pin_o(bclk_o), .bit_clock_pin_oe_o(bclk_oe), .frame_sync_pin_i(fs_w),
    .frame_sync_pin_o(fs_o), .frame_sync_pin_oe_o(fs_oe), .serial_data_in_pin_o(sdi_o),
    .serial_data_in_pin_oe_o(sdi_oe), .serial_data_out_pin_o(sdo_o),
    .serial_data_out_pin_oe_o(sdo_oe), .output_latch_reg_i(latch),
    .pin_direction_reg_i(dir));

  // System clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == CEIL) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Disable, let the link settle, then configure and enable
  task automatic setup(input logic [1:0] mode, input logic d, input logic [3:0] ws,
                       input logic [3:0] fl);
    logic [31:0] a;
    a = {27'h0, 1'b0, mode, d, 1'b0};
    wb(1'b1, codec_pkg::OFS_CTRL_A, 32'h0, 4'hF);
    repeat (8) @(posedge bclk_w);
    wb(1'b1, codec_pkg::OFS_CTRL_B, {24'h0, fl, ws}, 4'hF);
    wb(1'b1, codec_pkg::OFS_CTRL_A, a, 4'hF);
    wb(1'b1, codec_pkg::OFS_CTRL_A, a | 32'h1, 4'hF);
  endtask

  // Sync high length and rise-to-rise period, sampled mid bit
  task automatic meas(output int h, output int p);
    int n;
    h = 0;
    @(negedge bclk_w);
    for (n = 0; n < 600 && fs_w !== 1'b0; n++) @(negedge bclk_w);
    for (n = 0; n < 600 && fs_w !== 1'b1; n++) @(negedge bclk_w);
    for (n = 0; n < 600 && fs_w === 1'b1; n++) begin
      h++;
      @(negedge bclk_w);
    end
    p = h;
    for (n = 0; n < 600 && fs_w !== 1'b1; n++) begin
      p++;
      @(negedge bclk_w);
    end
  endtask

  initial begin
    arst_n_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    latch = 4'h5;
    dir = 4'hA;
    run = 1'b1;
    slave = 1'b0;
    len = 9'h004;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // Reset values, unmapped read, port pass-through while disabled
    wb(1'b0, codec_pkg::OFS_CTRL_A, 32'h0, 4'hF);
    `CHK("ctrl_a reset", 32'h0, rd)
    wb(1'b0, codec_pkg::OFS_CTRL_B, 32'h0, 4'hF);
    `CHK("ctrl_b reset", 32'h0, rd)
    wb(1'b0, codec_pkg::OFS_STATUS, 32'h0, 4'hF);
    `CHK("status reset", 32'h0, rd)
    wb(1'b0, 8'hFC, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, rd)
    `CHK("port pins", 8'hCC, pins)
    dir <= 4'hF;
    // Master framing in every mode
    foreach (rows[i]) begin
      setup(rows[i].mode, 1'b0, rows[i].ws, rows[i].fl);
      wb(1'b0, codec_pkg::OFS_CTRL_A, 32'h0, 4'hF);
      `CHK("ctrl_a", {27'h0, 1'b0, rows[i].mode, 2'h1}, rd)
      wb(1'b0, codec_pkg::OFS_CTRL_B, 32'h0, 4'hF);
      `CHK("ctrl_b", {24'h0, rows[i].fl, rows[i].ws}, rd)
      `CHK("pin enables", 4'h5, {bclk_oe, fs_oe, sdi_oe, sdo_oe})
      `CHK("data pin drive", 2'h0, {sdi_o, sdo_o})
      meas(hi, per);
      `CHK("sync high", rows[i].hi, hi)
      `CHK("frame length", rows[i].per, per)
      wb(1'b0, codec_pkg::OFS_STATUS, 32'h0, 4'hF);
      `CHK("link active", 1'b1, rd[0])
      wb(1'b1, codec_pkg::OFS_CTRL_A, 32'h0, 4'hF);
      repeat (8) @(posedge bclk_w);
      wb(1'b0, codec_pkg::OFS_STATUS, 32'h0, 4'hF);
      `CHK("cleared", 17'h0, {rd[31:16], rd[0]})
    end
    // Byte 0 not selected leaves the control word alone
    wb(1'b1, codec_pkg::OFS_CTRL_B, 32'h77, 4'hE);
    wb(1'b0, codec_pkg::OFS_CTRL_B, 32'h0, 4'hF);
    `CHK("sel off", 32'h0, rd)
    // Generator alone drives the bit clock
    run <= 1'b0;
    wb(1'b1, codec_pkg::OFS_CTRL_A, 32'h10, 4'hF);
    @(posedge clk_i);
    `CHK("gen pins", 4'h8, {bclk_oe, fs_oe, sdi_oe, sdo_oe})
    tg = 0;
    for (int k = 0; k < 200; k++) begin
      logic b;
      b = bclk_o;
      @(posedge clk_i);
      #1;
      if (bclk_o !== b) tg++;
    end
    `CHK("gen toggles", 1'b1, (tg >= 200 / HALF - 1 && tg <= 200 / HALF + 1))
    wb(1'b1, codec_pkg::OFS_CTRL_A, 32'h0, 4'hF);
    run <= 1'b1;
    // Codec as frame sync master, device follows
    slave <= 1'b1;
    setup(2'h0, 1'b1, 4'h1, 4'h1);
    repeat (20) @(posedge bclk_w);
    `CHK("slave fs enable", 1'b0, fs_oe)
    wb(1'b0, codec_pkg::OFS_STATUS, 32'h0, 4'hF);
    s1 = rd;
    repeat (40) @(posedge bclk_w);
    wb(1'b0, codec_pkg::OFS_STATUS, 32'h0, 4'hF);
    tg = int'(rd[31:16] - s1[31:16]);
    `CHK("slave frames", 1'b1, (tg >= 10 && tg <= 11))
    // Locked while enabled
    wb(1'b1, codec_pkg::OFS_CTRL_B, 32'h55, 4'hF);
    wb(1'b0, codec_pkg::OFS_CTRL_B, 32'h0, 4'hF);
    `CHK("locked ctrl_b", 32'h11, rd)
    // Reset in mid-run returns registers and status to zero
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wb(1'b0, codec_pkg::OFS_CTRL_A, 32'h0, 4'hF);
    `CHK("ctrl_a mid reset", 32'h0, rd)
    wb(1'b0, codec_pkg::OFS_CTRL_B, 32'h0, 4'hF);
    `CHK("ctrl_b mid reset", 32'h0, rd)
    wb(1'b0, codec_pkg::OFS_STATUS, 32'h0, 4'hF);
    `CHK("status mid reset", 17'h0, {rd[31:16], rd[0]})
    give_verdict();
  end
endmodule
